// *** umf_pkg.sv ***
// Package for the modem handshake and interrupt control block
package umf_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_FLOW = 8'h00;
  localparam logic [7:0] OFF_IEN_SET = 8'h04;
  localparam logic [7:0] OFF_IEN_CLR = 8'h08;
  localparam logic [7:0] OFF_IEN = 8'h0c;
  localparam logic [7:0] OFF_RAW = 8'h10;
  localparam logic [7:0] OFF_MASKED = 8'h14;
  localparam logic [7:0] OFF_ACK = 8'h18;
  localparam logic [7:0] OFF_HS_SET = 8'h1c;
  localparam logic [7:0] OFF_HS_CLR = 8'h20;
  localparam logic [7:0] OFF_HS_STAT = 8'h24;
  localparam logic [7:0] OFF_MDM_STAT = 8'h28;
  localparam logic [7:0] OFF_TXDATA = 8'h2c;
  localparam logic [7:0] OFF_RXDATA = 8'h30;
  // ----------------------------------------
  // Interrupt source bit positions, one map for every view
  // ----------------------------------------
  localparam int NUM_IRQ = 12;
  localparam int BIT_RI = 0;
  localparam int BIT_CTS = 1;
  localparam int BIT_DCD = 2;
  localparam int BIT_DSR = 3;
  localparam int BIT_RX = 4;
  localparam int BIT_TX = 5;
  localparam int BIT_RT = 6;
  localparam int BIT_FE = 7;
  localparam int BIT_PE = 8;
  localparam int BIT_BE = 9;
  localparam int BIT_OE = 10;
  localparam int BIT_ADDR = 11;
  // ----------------------------------------
  // Control field positions
  // ----------------------------------------
  localparam int FLOW_TX_BIT = 0;
  localparam int FLOW_RX_BIT = 1;
  localparam int HS_DTR_BIT = 0;
  localparam int HS_RTS_BIT = 1;
  localparam int MS_RI_BIT = 0;
  localparam int MS_DCD_BIT = 1;
  localparam int MS_DSR_BIT = 2;
  localparam int MS_CTS_BIT = 3;
  localparam logic [11:0] IRQ_RESET = 12'h000;
  localparam int FIFO_DEPTH = 32;
  localparam int DATA_W = 8;
endpackage

// *** umf_fifo_if.sv ***
// Stream carrier between the top and the receive buffer
`timescale 1ns/1ps
`default_nettype none
interface umf_fifo_if #(parameter int WIDTH = 8);
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [WIDTH-1:0] out_data;
  modport fifo (input in_valid, in_data, out_ready,
    output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready,
    input in_ready, out_valid, out_data);
endinterface
`default_nettype wire

// *** umf_fifo.sv ***
// Receive buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module umf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
)(
  input wire logic pclk,
  input wire logic presetn,
  umf_fifo_if.fifo s
);
  localparam int AW = $clog2(DEPTH);
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("umf_fifo: DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_q, wp_d, rp_q, rp_d;
  logic full, empty, push, pop;
  assign empty = (wp_q == rp_q);
  assign full = (wp_q[AW-1:0] == rp_q[AW-1:0]) && (wp_q[AW] != rp_q[AW]);
  assign s.in_ready = !full;
  assign s.out_valid = !empty;
  assign s.out_data = mem[rp_q[AW-1:0]];
  assign push = s.in_valid && !full;
  assign pop = s.out_ready && !empty;
  always_comb
  begin
    wp_d = wp_q + (AW+1)'(push);
    rp_d = rp_q + (AW+1)'(pop);
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wp_q <= '0;
      rp_q <= '0;
    end
    else
    begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end
  always_ff @(posedge pclk)
  begin
    if (push)
      mem[wp_q[AW-1:0]] <= s.in_data;
  end
endmodule
`default_nettype wire

// *** umf_top.sv ***
// Modem handshake, flow control and interrupt mask block with APB access
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module umf_top
  import umf_pkg::*;
#(
  parameter int FIFO_D = FIFO_DEPTH
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ring_in,
  input wire logic carrier_in,
  input wire logic dsr_in,
  input wire logic cts_in,
  output logic dtr_out,
  output logic rts_out,
  output logic irq,
  input wire logic [DATA_W-1:0] rx_char,
  input wire logic rx_char_valid,
  input wire logic [5:0] rx_err_events,
  output logic tx_start,
  output logic [DATA_W-1:0] tx_char,
  input wire logic tx_busy,
  input wire logic tx_done
);
  initial
  begin
    if (FIFO_D < 2)
      $error("umf_top: FIFO_D too small");
  end
  // ----------------------------------------
  // Receive FIFO
  // ----------------------------------------
  umf_fifo_if #(.WIDTH(DATA_W)) rxf ();
  umf_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_D)) u_rxfifo (
    .pclk(pclk),
    .presetn(presetn),
    .s(rxf)
  );
  // ----------------------------------------
  // Modem input synchronisers
  // ----------------------------------------
  logic [3:0] mdm_raw, mdm_s1_q, mdm_s2_q, mdm_s3_q;
  assign mdm_raw = {cts_in, dsr_in, carrier_in, ring_in};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mdm_s1_q <= 4'h0;
      mdm_s2_q <= 4'h0;
      mdm_s3_q <= 4'h0;
    end
    else
    begin
      mdm_s1_q <= mdm_raw;
      mdm_s2_q <= mdm_s1_q;
      mdm_s3_q <= mdm_s2_q;
    end
  end
  logic [3:0] mdm_chg;
  assign mdm_chg = mdm_s2_q ^ mdm_s3_q;
  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic wr_en, rd_en, hit;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  always_comb
  begin
    case (paddr)
      OFF_FLOW, OFF_IEN_SET, OFF_IEN_CLR, OFF_IEN, OFF_RAW, OFF_MASKED,
      OFF_ACK, OFF_HS_SET, OFF_HS_CLR, OFF_HS_STAT, OFF_MDM_STAT,
      OFF_TXDATA, OFF_RXDATA: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  // ----------------------------------------
  // Control state
  // ----------------------------------------
  logic [1:0] flow_q, flow_d;
  logic [1:0] hs_q, hs_d;
  logic [NUM_IRQ-1:0] ien_q, ien_d, raw_q, raw_d, ev, ack;
  logic tx_pend_q, tx_pend_d;
  logic [DATA_W-1:0] tx_buf_q, tx_buf_d;
  logic tx_start_q, tx_start_d;
  logic rts_q, rts_d, dtr_q, dtr_d, irq_q, irq_d;
  logic [31:0] prdata_q, prdata_d;
  logic pslverr_q, pslverr_d;
  logic tx_ok;
  logic [NUM_IRQ-1:0] ien_set, ien_clr;
  logic [1:0] hs_set, hs_clr;
  always_comb
  begin
    ev = '0;
    ev[BIT_RI] = mdm_chg[MS_RI_BIT];
    ev[BIT_DCD] = mdm_chg[MS_DCD_BIT];
    ev[BIT_DSR] = mdm_chg[MS_DSR_BIT];
    ev[BIT_CTS] = mdm_chg[MS_CTS_BIT];
    ev[BIT_RX] = rx_char_valid && rxf.in_ready;
    ev[BIT_TX] = tx_done;
    ev[BIT_RT] = rx_err_events[0];
    ev[BIT_FE] = rx_err_events[1];
    ev[BIT_PE] = rx_err_events[2];
    ev[BIT_BE] = rx_err_events[3];
    ev[BIT_OE] = rx_err_events[4] || (rx_char_valid && !rxf.in_ready);
    ev[BIT_ADDR] = rx_err_events[5];
  end
  assign ack = (wr_en && paddr == OFF_ACK) ? pwdata[NUM_IRQ-1:0] : '0;
  assign ien_set = (wr_en && paddr == OFF_IEN_SET) ? pwdata[NUM_IRQ-1:0] : '0;
  assign ien_clr = (wr_en && paddr == OFF_IEN_CLR) ? pwdata[NUM_IRQ-1:0] : '0;
  assign hs_set = (wr_en && paddr == OFF_HS_SET) ? pwdata[1:0] : 2'b00;
  assign hs_clr = (wr_en && paddr == OFF_HS_CLR) ? pwdata[1:0] : 2'b00;
  // Transmit gate; only a fresh start waits, a running character finishes
  assign tx_ok = !flow_q[FLOW_TX_BIT] || mdm_s2_q[MS_CTS_BIT];
  assign rxf.in_valid = rx_char_valid;
  assign rxf.in_data = rx_char;
  assign rxf.out_ready = rd_en && paddr == OFF_RXDATA;
  always_comb
  begin
    flow_d = flow_q;
    if (wr_en && paddr == OFF_FLOW)
      flow_d = pwdata[1:0];
    ien_d = (ien_q | ien_set) & ~ien_clr;
    // Set wins over acknowledge in the same cycle
    raw_d = (raw_q & ~ack) | ev;
    hs_d = (hs_q | hs_set) & ~hs_clr;
    dtr_d = hs_d[HS_DTR_BIT];
    if (flow_q[FLOW_RX_BIT])
      rts_d = rxf.in_ready;
    else
      rts_d = hs_d[HS_RTS_BIT];
    irq_d = |(raw_d & ien_d);
    tx_pend_d = tx_pend_q;
    tx_buf_d = tx_buf_q;
    tx_start_d = 1'b0;
    if (tx_pend_q && tx_ok && !tx_busy && !tx_start_q)
    begin
      tx_start_d = 1'b1;
      tx_pend_d = 1'b0;
    end
    else if (wr_en && paddr == OFF_TXDATA && !tx_pend_q)
    begin
      tx_pend_d = 1'b1;
      tx_buf_d = pwdata[DATA_W-1:0];
    end
    prdata_d = 32'h0000_0000;
    pslverr_d = 1'b0;
    if (psel && !penable)
    begin
      pslverr_d = !hit;
      case (paddr)
        OFF_FLOW: prdata_d[1:0] = flow_q;
        OFF_IEN: prdata_d[NUM_IRQ-1:0] = ien_q;
        OFF_RAW: prdata_d[NUM_IRQ-1:0] = raw_q;
        OFF_MASKED: prdata_d[NUM_IRQ-1:0] = raw_q & ien_q;
        OFF_HS_STAT:
        begin
          prdata_d[HS_DTR_BIT] = dtr_q;
          prdata_d[HS_RTS_BIT] = rts_q;
        end
        OFF_MDM_STAT: prdata_d[3:0] = mdm_s2_q;
        OFF_TXDATA: prdata_d[0] = tx_pend_q;
        OFF_RXDATA:
        begin
          prdata_d[DATA_W-1:0] = rxf.out_data;
          prdata_d[31] = !rxf.out_valid;
        end
        default: prdata_d = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flow_q <= 2'b00;
      hs_q <= 2'b00;
      ien_q <= IRQ_RESET;
      raw_q <= IRQ_RESET;
      tx_pend_q <= 1'b0;
      tx_buf_q <= '0;
      tx_start_q <= 1'b0;
      rts_q <= 1'b0;
      dtr_q <= 1'b0;
      irq_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      flow_q <= flow_d;
      hs_q <= hs_d;
      ien_q <= ien_d;
      raw_q <= raw_d;
      tx_pend_q <= tx_pend_d;
      tx_buf_q <= tx_buf_d;
      tx_start_q <= tx_start_d;
      rts_q <= rts_d;
      dtr_q <= dtr_d;
      irq_q <= irq_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Read data captured in setup, so access phase always completes at once
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign pready = 1'b1;
  assign dtr_out = dtr_q;
  assign rts_out = rts_q;
  assign irq = irq_q;
  assign tx_start = tx_start_q;
  assign tx_char = tx_buf_q;
endmodule
`default_nettype wire

// *** umf_top_sva.sv ***
// Port checker for the modem handshake and interrupt block
`timescale 1ns/1ps
`default_nettype none
module umf_top_sva
  import umf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic ring_in,
  input wire logic cts_in,
  input wire logic dtr_out,
  input wire logic rts_out,
  input wire logic irq,
  input wire logic tx_start
);
  // ------
  // Shadow state
  // ------
  logic wr;
  logic [11:0] ien_q, ien_d;
  logic [1:0] flow_q, flow_d;
  logic [2:0] low_q, low_d;
  assign wr = psel && penable && pwrite;
  always_comb
  begin
    ien_d = ien_q;
    flow_d = flow_q;
    // Saturates so a long low spell never wraps back to zero
    low_d = cts_in ? 3'h0 : low_q + {2'h0, low_q != 3'h7};
    if (wr && paddr == OFF_IEN_SET)
      ien_d = ien_q | pwdata[11:0];
    if (wr && paddr == OFF_IEN_CLR)
      ien_d = ien_q & ~pwdata[11:0];
    if (wr && paddr == OFF_FLOW)
      flow_d = pwdata[1:0];
  end
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      {ien_q, flow_q, low_q} <= '0;
    else
      {ien_q, flow_q, low_q} <= {ien_d, flow_d, low_d};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_hs(logic [7:0] a, int b);
    wr && paddr == a && pwdata[b];
  endsequence
  a_dtr_set: assert property (s_hs(OFF_HS_SET, 0) |=> dtr_out)
    else $error("dtr not raised");
  a_dtr_clear: assert property (s_hs(OFF_HS_CLR, 0) |=> !dtr_out)
    else $error("dtr not lowered");
  a_rts_sw_set: assert property (s_hs(OFF_HS_SET, 1) |=> flow_q[1] || rts_out)
    else $error("rts not raised");
  a_rts_sw_clear: assert property (s_hs(OFF_HS_CLR, 1) |=> flow_q[1] || !rts_out)
    else $error("rts not lowered");
  a_dtr_only_write: assert property ($changed(dtr_out) |-> $past(wr) &&
    ($past(paddr) == OFF_HS_SET || $past(paddr) == OFF_HS_CLR))
    else $error("dtr moved without a write");
  a_tx_cts_gate: assert property (tx_start && flow_q[0] |-> low_q < 3'h5)
    else $error("start while clear-to-send low");
  // The mask that produced irq is the one standing after the same edge
  a_irq_enabled: assert property (irq |-> ien_q != 12'h000)
    else $error("irq with empty mask");
  a_irq_mask_off: assert property (wr && paddr == OFF_IEN_CLR &&
    pwdata[11:0] == 12'hfff |=> ##1 !irq)
    else $error("irq after full disable");
  a_ring_irq: assert property (ien_q[BIT_RI] && $changed(ring_in) |->
    ##[1:10] irq)
    else $error("ring change raised no irq");
endmodule
`default_nettype wire

// *** umf_partner.sv ***
// Remote modem model: status levels and paced received characters
`timescale 1ns/1ps
`default_nettype none
module umf_partner
  import umf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] lvl,
  input wire logic send,
  input wire logic rts_out,
  output logic ring_in,
  output logic carrier_in,
  output logic dsr_in,
  output logic cts_in,
  output logic [7:0] rx_char,
  output logic rx_char_valid,
  output logic [7:0] sent
);
  logic [1:0] gap_q;
  assign {cts_in, dsr_in, carrier_in, ring_in} = lvl;
  // Data bus holds the inverted byte when idle so a stale byte is never taken
  assign rx_char = rx_char_valid ? sent : ~sent;
  // One character per four cycles, only while request-to-send is seen
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gap_q <= 2'h0;
      rx_char_valid <= 1'b0;
      sent <= 8'h00;
    end
    else
    begin
      gap_q <= gap_q + 2'h1;
      rx_char_valid <= send && rts_out && gap_q == 2'h0;
      if (send && rts_out && gap_q == 2'h0)
        sent <= sent + 8'h01;
    end
  end
endmodule
`default_nettype wire

// *** uart_modem_flow_and_irq_control_tb.sv ***
// Self-checking bench for the modem handshake and interrupt block
`timescale 1ns/1ps
`default_nettype none
module uart_modem_flow_and_irq_control_tb;
  import umf_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, rx_char, tx_char, sent, last_c, tc;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, se, ring_in, carrier_in, dsr_in, cts_in;
  logic dtr_out, rts_out, irq, tx_start, rx_char_valid;
  logic tx_busy = 0, tx_done = 0, send = 0;
  logic [5:0] rx_err_events = 6'h00;
  logic [3:0] lvl = 4'h0, nl, dif;
  logic [11:0] e, c, a;
  logic [7:0] hst = 8'b00101101;
  int mismatches = 0, checked = 0, starts = 0;
  integer seed = 32'h5e48a9ed;
  initial forever #5 pclk = ~pclk;
  umf_top #(.FIFO_D(FIFO_DEPTH)) dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ring_in,
    .carrier_in, .dsr_in, .cts_in, .dtr_out, .rts_out, .irq, .rx_char,
    .rx_char_valid, .rx_err_events, .tx_start, .tx_char, .tx_busy, .tx_done);
  umf_partner mdm (.pclk, .presetn, .lvl, .send, .rts_out, .ring_in,
    .carrier_in, .dsr_in, .cts_in, .rx_char, .rx_char_valid, .sent);
  always @(posedge pclk)
    if (tx_start)
    begin
      starts <= starts + 1;
      last_c <= tx_char;
    end
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
    checked++;
    if (s !== x)
    begin
      $display("BAD %s expected %h seen %h", n, x, s);
      mismatches++;
    end
  endtask
  task automatic apb(input logic [7:0] ad, input logic w, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    r = prdata;
    se = pslverr;
    if (n == 20)
      mismatches++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(ad, 1'b1, d);
  endtask
  task automatic cr(input string n, input logic [7:0] ad,
    input logic [31:0] x, input logic [31:0] m);
    apb(ad, 1'b0, 32'h0);
    chk(n, x, r & m);
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask
  function automatic logic [11:0] mmap(input logic [3:0] d);
    return {8'h00, d[2], d[1], d[3], d[0]};
  endfunction
  task automatic stop_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ------
  // Scenarios
  // ------
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    cr("ien", OFF_IEN, 0, 'hfff);
    cr("raw", OFF_RAW, 0, 'hfff);
    apb(8'h3c, 1'b0, 32'h0);
    chk("slverr", 1, se);
    for (int i = 0; i < 4; i++)
    begin
      wr(i < 2 ? OFF_HS_SET : OFF_HS_CLR, 32'(i % 2 + 1));
      cr("hs", OFF_HS_STAT, hst[2*i+:2], 3);
      tick(1);
      chk("pins", hst[2*i+:2], {rts_out, dtr_out});
    end
    $display("handshake test done");
    wr(OFF_IEN_SET, 1);
    for (int i = 0; i < 4; i++)
    begin
      nl = i == 0 ? 4'hf : 4'($random(seed));
      dif = nl ^ lvl;
      lvl <= nl;
      tick(12);
      cr("mdm", OFF_MDM_STAT, nl, 'hf);
      cr("chg", OFF_RAW, mmap(dif), 'hfff);
      a = 12'($random(seed));
      wr(OFF_ACK, a);
      cr("ack", OFF_RAW, mmap(dif) & ~a, 'hfff);
      wr(OFF_ACK, 'hfff);
    end
    $display("modem test done");
    wr(OFF_IEN_CLR, 'hfff);
    for (int i = 0; i < 3; i++)
    begin
      e = i == 0 ? 12'h800 : 12'($random(seed));
      c = i == 0 ? 12'h000 : 12'($random(seed));
      wr(OFF_IEN_SET, e);
      wr(OFF_IEN_CLR, c);
      e = e & ~c;
      rx_err_events <= 6'h3f;
      tick(1);
      rx_err_events <= 6'h00;
      cr("ien", OFF_IEN, e, 'hfff);
      cr("raw", OFF_RAW, 'hfc0, 'hfff);
      cr("mask", OFF_MASKED, 'hfc0 & e, 'hfff);
      tick(1);
      chk("irq", |(e & 12'hfc0), irq);
      wr(OFF_ACK, 'hfff);
      wr(OFF_IEN_CLR, 'hfff);
    end
    $display("interrupt test done");
    tc = 8'($random(seed));
    wr(OFF_FLOW, 1);
    lvl <= 4'h0;
    tick(6);
    wr(OFF_TXDATA, tc);
    tick(8);
    chk("gated", 0, starts);
    lvl <= 4'h8;
    tick(8);
    chk("start", 1, starts);
    chk("char", tc, last_c);
    wr(OFF_FLOW, 0);
    lvl <= 4'h0;
    tick(6);
    wr(OFF_TXDATA, ~tc);
    tick(8);
    chk("free", 2, starts);
    tx_done <= 1'b1;
    tick(1);
    tx_done <= 1'b0;
    cr("txirq", OFF_RAW, 'h20, 'h20);
    wr(OFF_ACK, 'hfff);
    $display("transmit test done");
    wr(OFF_FLOW, 2);
    send <= 1'b1;
    tick(200);
    chk("sent", FIFO_DEPTH, sent);
    chk("rts full", 0, rts_out);
    wr(OFF_HS_SET, 2);
    send <= 1'b0;
    tick(2);
    chk("rts hw", 0, rts_out);
    cr("ovr", OFF_RAW, 0, 'h400);
    for (int i = 1; i <= FIFO_DEPTH; i++)
    begin
      apb(OFF_RXDATA, 1'b0, 32'h0);
      chk("rx", i, {r[31], r[7:0]});
    end
    cr("empty", OFF_RXDATA, 'h80000000, 'h80000000);
    tick(2);
    chk("rts room", 1, rts_out);
    wr(OFF_FLOW, 0);
    wr(OFF_HS_CLR, 2);
    tick(2);
    chk("rts sw", 0, rts_out);
    $display("buffer test done");
    stop_test;
  end
  initial
  begin
    #100000;
    mismatches++;
    stop_test;
  end
endmodule
bind umf_top umf_top_sva chk_i (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .ring_in, .cts_in, .dtr_out, .rts_out, .irq, .tx_start);
`default_nettype wire
